// ---- hdl/sync_device.sv ----
// Notes on behaviour
// - start delayed by 16-bit hold-off count
// - reset puts all four channels asleep
// - host sleeps channels, loads count first
// - external soft write starts selected counters
// - start count of one wakes channel
// - per-channel soft register mirrors start/hop bits
// - soft start: count plus six after acknowledge
// - four sync pins, any per channel
// - host enables start-on-pin and pin enables
// - select field 00..11 picks pin a..d
// - selected pin rising edge triggers start counter
// - pin retriggers unless first-only set
// - per-channel pin register mirrors bits 6..4
// - pin start: count plus three after pin
// - waking from sleep issues start and hop
// - hop delayed by nonzero hop count
// - new frequency shadowed, loaded at one
// - soft hop bit starts hop counters
// - soft hop: count plus seven after acknowledge
// - host enables hop-on-pin, pins, selects
// - pin sample rising edge starts hop countdown
// - pin hop: count plus five after pin
// - zero start count keeps channel asleep
`timescale 1ns/1ps
`default_nettype none
module sync_device
  import sync_pkg::*;
#(
  parameter int unsigned CNT_W = 16  // hold-off counter width
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  sync_port_if.dev                   port,
  output var  logic [NUM_CH-1:0]     channel_awake,
  output var  logic [NUM_CH-1:0]     nco_load,
  output var  logic [NUM_CH-1:0][31:0] nco_freq
);
  // refuse counter widths the registers cannot hold
  if (CNT_W < 2 || CNT_W > DATA_W) begin : g_bad_width
    $error("sync_device: CNT_W must be 2..16");
  end

  logic [1:0]       ch;                         // addressed channel
  logic [7:0]       off;                        // addressed offset
  logic [7:0]       pin_ext;                    // external pin register
  logic [7:0]       soft_ext;                   // external soft register
  logic [1:0]       soft_mir [NUM_CH];          // [0] start, [1] hop
  logic [2:0]       pin_mir  [NUM_CH];          // [0] start, [1] hop, [2] first
  logic [1:0]       pin_sel  [NUM_CH];          // chosen sync pin
  logic [CNT_W-1:0] start_reg [NUM_CH];         // start hold-off
  logic [CNT_W-1:0] freq_reg  [NUM_CH];         // hop hold-off
  logic [15:0]      flo [NUM_CH];               // shadow frequency low
  logic [15:0]      fhi [NUM_CH];               // shadow frequency high
  logic [CNT_W-1:0] start_cnt [NUM_CH];         // start counters
  logic [CNT_W-1:0] freq_cnt  [NUM_CH];         // hop counters
  logic [NUM_CH-1:0] seen;                      // first pin trigger taken
  logic [3:0]       pin_q;                      // sampled pins
  logic [3:0]       pin_q2;                     // previous sample
  logic [3:0]       pin_rise;                   // new high level on a pin
  logic [NUM_CH-1:0] soft_start, soft_hop;      // soft requests this cycle
  logic [NUM_CH-1:0] pin_start, pin_hop;        // pin requests this cycle
  logic [NUM_CH-1:0] pin_hit;                   // pin trigger accepted
  logic [HIST_DEPTH-1:0][NUM_CH-1:0] ss_hist, sh_hist, ps_hist, ph_hist;
  logic [15:0]      rd_val;                     // read mux

  assign ch       = port.port_addr[CH_LSB +: 2];
  assign off      = port.port_addr[7:0];
  assign pin_rise = pin_q & ~pin_q2;

  // write strobe decode helper
  function automatic logic wr_to(input logic [7:0] o);
    return port.port_wr && (off == o);
  endfunction : wr_to

  // software and pin request decode
  always_comb begin
    soft_start = '0;
    soft_hop   = '0;
    pin_start  = '0;
    pin_hop    = '0;
    pin_hit    = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      // external soft write: channel bits pick targets
      if (wr_to(EXT_SOFT) && port.port_wdata[c]) begin
        soft_start[c] = port.port_wdata[START_BIT];
        soft_hop[c]   = port.port_wdata[HOP_BIT];
      end
      // channel's own soft register
      if (wr_to(CH_SOFT) && ch == 2'(c)) begin
        soft_start[c] = soft_start[c] | port.port_wdata[START_BIT];
        soft_hop[c]   = soft_hop[c] | port.port_wdata[HOP_BIT];
      end
      // clearing a sleep bit acts as a soft start and hop
      if (wr_to(EXT_SLEEP) && !channel_awake[c] && !port.port_wdata[c]) begin
        soft_start[c] = 1'b1;
        soft_hop[c]   = 1'b1;
      end
      // selected, enabled pin rising; first-only blocks repeats
      pin_hit[c] = pin_rise[pin_sel[c]] && pin_ext[pin_sel[c]]
                   && !(pin_mir[c][2] && seen[c]);
      pin_start[c] = pin_hit[c] && pin_mir[c][0];
      pin_hop[c]   = pin_hit[c] && pin_mir[c][1];
    end
  end

  // pin sampling and request history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q   <= '0;
      pin_q2  <= '0;
      ss_hist <= '0;
      sh_hist <= '0;
      ps_hist <= '0;
      ph_hist <= '0;
    end else begin
      pin_q   <= port.sync_pin;
      pin_q2  <= pin_q;
      // shift requests so each path meets its fixed latency
      ss_hist <= {ss_hist[HIST_DEPTH-2:0], soft_start};
      sh_hist <= {sh_hist[HIST_DEPTH-2:0], soft_hop};
      ps_hist <= {ps_hist[HIST_DEPTH-2:0], pin_start};
      ph_hist <= {ph_hist[HIST_DEPTH-2:0], pin_hop};
    end
  end

  // control and channel registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_ext  <= '0;
      soft_ext <= '0;
      seen     <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        soft_mir[c]  <= '0;
        pin_mir[c]   <= '0;
        pin_sel[c]   <= '0;
        start_reg[c] <= '0;
        freq_reg[c]  <= '0;
        flo[c]       <= '0;
        fhi[c]       <= '0;
      end
    end else begin
      // external writes fan out to every channel mirror
      if (wr_to(EXT_PIN)) begin
        pin_ext <= port.port_wdata[7:0];
        for (int c = 0; c < NUM_CH; c++)
          pin_mir[c] <= port.port_wdata[FIRST_BIT:START_BIT];
      end
      if (wr_to(EXT_SOFT)) begin
        soft_ext <= port.port_wdata[7:0];
        for (int c = 0; c < NUM_CH; c++)
          soft_mir[c] <= port.port_wdata[HOP_BIT:START_BIT];
      end
      for (int c = 0; c < NUM_CH; c++) begin
        // first-only latch, released when the bit is cleared
        if (!pin_mir[c][2]) seen[c] <= 1'b0;
        else if (pin_start[c] || pin_hop[c]) seen[c] <= 1'b1;
        if (port.port_wr && ch == 2'(c)) begin
          unique case (off)
            CH_SOFT:  soft_mir[c]  <= port.port_wdata[HOP_BIT:START_BIT];
            CH_PIN:   pin_mir[c]   <= port.port_wdata[FIRST_BIT:START_BIT];
            CH_START: start_reg[c] <= port.port_wdata[CNT_W-1:0];
            CH_FREQ:  freq_reg[c]  <= port.port_wdata[CNT_W-1:0];
            CH_FLO:   flo[c]       <= port.port_wdata;
            CH_FHI:   fhi[c]       <= port.port_wdata;
            CH_SEL:   pin_sel[c]   <= port.port_wdata[SEL_LSB +: 2];
            default:  ;
          endcase
        end
      end
    end
  end

  // hold-off counters, sleep state and nco load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_awake <= '0;
      nco_load      <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        start_cnt[c] <= '0;
        freq_cnt[c]  <= '0;
        nco_freq[c]  <= '0;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        // start counter: reload on trigger, a zero preload stays idle
        if (ss_hist[SOFT_START_TAP][c] || ps_hist[PIN_START_TAP][c])
          start_cnt[c] <= start_reg[c];
        else if (start_cnt[c] != '0)
          start_cnt[c] <= start_cnt[c] - 1'b1;
        // hop counter likewise
        if (sh_hist[SOFT_HOP_TAP][c] || ph_hist[PIN_HOP_TAP][c])
          freq_cnt[c] <= freq_reg[c];
        else if (freq_cnt[c] != '0)
          freq_cnt[c] <= freq_cnt[c] - 1'b1;
        // software sleep; the wake at count one wins the same cycle
        if (wr_to(EXT_SLEEP) && port.port_wdata[c]) channel_awake[c] <= 1'b0;
        if (start_cnt[c] == CNT_W'(1)) channel_awake[c] <= 1'b1;
        // shadow to working register at hop count one
        nco_load[c] <= (freq_cnt[c] == CNT_W'(1));
        if (freq_cnt[c] == CNT_W'(1)) nco_freq[c] <= {fhi[c], flo[c]};
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    unique case (off)
      EXT_SLEEP: rd_val = {12'h000, ~channel_awake};
      EXT_PIN:   rd_val = {8'h00, pin_ext};
      EXT_SOFT:  rd_val = {8'h00, soft_ext};
      CH_SOFT:   rd_val = {10'h000, soft_mir[ch], 4'h0};
      CH_PIN:    rd_val = {9'h000, pin_mir[ch], 4'h0};
      CH_START:  rd_val = 16'(start_reg[ch]);
      CH_FREQ:   rd_val = 16'(freq_reg[ch]);
      CH_FLO:    rd_val = flo[ch];
      CH_FHI:    rd_val = fhi[ch];
      CH_SEL:    rd_val = {7'h00, pin_sel[ch], 7'h00};
      default:   rd_val = 16'h0000;
    endcase
  end

  // acknowledge one cycle after any strobe, read data with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port.port_write_acknowledge <= 1'b0;
      port.port_rdata             <= '0;
    end else begin
      port.port_write_acknowledge <= port.port_wr | port.port_rd;
      if (port.port_rd) port.port_rdata <= rd_val;
    end
  end
endmodule : sync_device
`default_nettype wire

// ---- hdl/sync_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// apb-controlled host: issues port accesses and drives the sync pins
module sync_host
  import sync_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  sync_port_if.host        port
);
  typedef enum logic {IDLE, WAIT} host_state_t;

  host_state_t state;       // access sequencer
  logic [15:0] last_rdata;  // data of last port read
  logic        apb_wr;      // apb write takes effect
  logic        go_wr;       // start a port write
  logic        go_rd;       // start a port read

  assign apb_wr = psel && penable && pready && pwrite;
  assign go_wr  = apb_wr && paddr == H_CTRL && pwdata[CTRL_WR_BIT] && state == IDLE;
  assign go_rd  = apb_wr && paddr == H_CTRL && pwdata[CTRL_RD_BIT] && state == IDLE
                  && !pwdata[CTRL_WR_BIT];

  // apb answer: ready and data in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        unique case (paddr)
          H_ADDR:   prdata <= {22'h000000, port.port_addr};
          H_WDATA:  prdata <= {16'h0000, port.port_wdata};
          H_STATUS: prdata <= {31'h00000000, state == WAIT};
          H_RDATA:  prdata <= {16'h0000, last_rdata};
          H_SYNC:   prdata <= {28'h0000000, port.sync_pin};
          default:  prdata <= '0;
        endcase
      end
    end
  end

  // command registers and sync pin drive; address and data frozen while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port.port_addr  <= '0;
      port.port_wdata <= '0;
      port.sync_pin   <= '0;
    end else if (apb_wr) begin
      if (paddr == H_ADDR && state == IDLE) port.port_addr <= pwdata[9:0];
      if (paddr == H_WDATA && state == IDLE) port.port_wdata <= pwdata[15:0];
      if (paddr == H_SYNC) port.sync_pin <= pwdata[3:0];
    end
  end

  // port access sequencer: strobe once, wait for acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state        <= IDLE;
      port.port_wr <= 1'b0;
      port.port_rd <= 1'b0;
      last_rdata   <= '0;
    end else begin
      port.port_wr <= go_wr;
      port.port_rd <= go_rd;
      unique case (state)
        IDLE: if (go_wr || go_rd) state <= WAIT;
        WAIT: if (port.port_write_acknowledge) begin
          state      <= IDLE;
          last_rdata <= port.port_rdata;
        end
      endcase
    end
  end
endmodule : sync_host
`default_nettype wire

// ---- include/sync_pkg.sv ----
package sync_pkg;
  // channel count, fixed by the 4-bit channel fields of the external registers
  localparam int unsigned NUM_CH = 4;
  // device port address layout: [9:8] channel, [7:0] register offset
  localparam int unsigned ADDR_W   = 10;
  localparam int unsigned CH_LSB   = 8;
  localparam int unsigned DATA_W   = 16;
  // external register offsets (bit 7 low)
  localparam logic [7:0] EXT_SLEEP = 8'h03;
  localparam logic [7:0] EXT_PIN   = 8'h04;
  localparam logic [7:0] EXT_SOFT  = 8'h05;
  // channel register offsets (bit 7 high)
  localparam logic [7:0] CH_SOFT   = 8'h81;
  localparam logic [7:0] CH_PIN    = 8'h82;
  localparam logic [7:0] CH_START  = 8'h83;
  localparam logic [7:0] CH_FREQ   = 8'h84;
  localparam logic [7:0] CH_FLO    = 8'h85;
  localparam logic [7:0] CH_FHI    = 8'h86;
  localparam logic [7:0] CH_SEL    = 8'h88;
  // field positions
  localparam int unsigned START_BIT = 4;  // start request / start on pin
  localparam int unsigned HOP_BIT   = 5;  // hop request / hop on pin
  localparam int unsigned FIRST_BIT = 6;  // first trigger only
  localparam int unsigned SEL_LSB   = 7;  // pin select field [8:7]
  // latencies in clocks, trigger source to effect (plus hold-off count)
  localparam int unsigned SOFT_START_LAT = 6;
  localparam int unsigned PIN_START_LAT  = 3;
  localparam int unsigned SOFT_HOP_LAT   = 7;
  localparam int unsigned PIN_HOP_LAT    = 5;
  // history taps that realise those latencies
  localparam int unsigned SOFT_START_TAP = SOFT_START_LAT - 1;
  localparam int unsigned SOFT_HOP_TAP   = SOFT_HOP_LAT - 1;
  localparam int unsigned PIN_START_TAP  = PIN_START_LAT - 3;
  localparam int unsigned PIN_HOP_TAP    = PIN_HOP_LAT - 3;
  localparam int unsigned HIST_DEPTH     = SOFT_HOP_TAP + 1;
  // host apb register offsets
  localparam logic [7:0] H_ADDR   = 8'h00;
  localparam logic [7:0] H_WDATA  = 8'h04;
  localparam logic [7:0] H_CTRL   = 8'h08;
  localparam logic [7:0] H_STATUS = 8'h0c;
  localparam logic [7:0] H_RDATA  = 8'h10;
  localparam logic [7:0] H_SYNC   = 8'h14;
  localparam int unsigned CTRL_WR_BIT = 0;
  localparam int unsigned CTRL_RD_BIT = 1;
endpackage : sync_pkg

// ---- include/sync_port_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// microprocessor port plus the four sync pins
interface sync_port_if;
  logic [9:0]  port_addr;               // channel and offset
  logic [15:0] port_wdata;              // write data
  logic        port_wr;                 // one-cycle write strobe
  logic        port_rd;                 // one-cycle read strobe
  logic [15:0] port_rdata;              // read data, valid with acknowledge
  logic        port_write_acknowledge;  // one-cycle acknowledge
  logic [3:0]  sync_pin;                // sync pins a..d

  modport dev (input port_addr, port_wdata, port_wr, port_rd, sync_pin,
               output port_rdata, port_write_acknowledge);
  modport host (output port_addr, port_wdata, port_wr, port_rd, sync_pin,
                input port_rdata, port_write_acknowledge);
endinterface : sync_port_if
`default_nettype wire

// ---- tb/sync_port_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// protocol checks on the port between host and device
module sync_port_asserts
  import sync_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [9:0]  port_addr,
  input wire logic [15:0] port_wdata,
  input wire logic        port_wr,
  input wire logic        port_rd,
  input wire logic [15:0] port_rdata,
  input wire logic        port_write_acknowledge,
  input wire logic [3:0]  sync_pin
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic stb = port_wr | port_rd;  // any request

  a_ack_after_strobe: assert property (
    stb |=> port_write_acknowledge) else $error("no ack after strobe");
  a_ack_has_cause: assert property (
    port_write_acknowledge |-> $past(stb)) else $error("ack without strobe");
  a_ack_one_cycle: assert property (
    port_write_acknowledge |=> !port_write_acknowledge) else $error("ack too long");
  a_one_outstanding: assert property (
    stb |=> !stb) else $error("second strobe before ack");
  a_strobe_excl: assert property (
    !(port_wr && port_rd)) else $error("read and write together");
  a_rdata_hold: assert property (
    $changed(port_rdata) |-> $past(port_rd)) else $error("read data moved");
  a_sel_field: assert property (
    port_rd && port_addr[7:0] == CH_SEL |=> port_rdata[15:9] == 7'h0
    && port_rdata[6:0] == 7'h0) else $error("select reg extra bits");
  a_pin_reg_bits: assert property (
    port_rd && port_addr[7:0] == EXT_PIN |=> port_rdata[15:7] == 9'h0)
    else $error("pin reg extra bits");
endmodule : sync_port_asserts
`default_nettype wire

// ---- tb/tb_channel_start_hop_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_channel_start_hop_sync
  import sync_pkg::*;
;
  logic                    pclk    = 1'b0;
  logic                    presetn = 1'b0;
  logic                    psel    = 1'b0;
  logic                    penable = 1'b0;
  logic                    pwrite  = 1'b0;
  logic [7:0]              paddr   = 8'h00;
  logic [31:0]             pwdata  = 32'h0;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic [NUM_CH-1:0]       awake;
  logic [NUM_CH-1:0]       load;
  logic [NUM_CH-1:0][31:0] freq;
  logic [3:0]              prev_pin   = 4'h0;  // pins one edge ago
  logic [NUM_CH-1:0]       prev_awake = 4'h0;
  logic [31:0]             rd;                 // last apb read data
  int                      cyc, ack_at, pin_at, err_total, comparisons, n;
  int                      wake_at [NUM_CH];
  int                      load_at [NUM_CH];
  int                      load_cnt [NUM_CH];

  sync_port_if port ();
  sync_host sync_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port(port));
  sync_device #(.CNT_W(16)) sync_device_i (.pclk(pclk), .presetn(presetn), .port(port),
    .channel_awake(awake), .nco_load(load), .nco_freq(freq));
  sync_port_asserts sync_port_asserts_i (.pclk(pclk), .presetn(presetn),
    .port_addr(port.port_addr), .port_wdata(port.port_wdata), .port_wr(port.port_wr),
    .port_rd(port.port_rd), .port_rdata(port.port_rdata), .sync_pin(port.sync_pin),
    .port_write_acknowledge(port.port_write_acknowledge));

  always #2 pclk = ~pclk;

  // timestamps of ack, pin rise, wake and load, in edges
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    prev_pin <= port.sync_pin;
    prev_awake <= awake;
    if (port.port_write_acknowledge === 1'b1) ack_at <= cyc;
    if ((port.sync_pin & ~prev_pin) != 4'h0) pin_at <= cyc;
    for (int c = 0; c < NUM_CH; c++) begin
      if (awake[c] === 1'b1 && prev_awake[c] !== 1'b1) wake_at[c] <= cyc;
      if (load[c] === 1'b1) begin
        load_at[c] <= cyc;
        load_cnt[c] <= load_cnt[c] + 1;
      end
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // device port access through the host registers
  task automatic acc(input logic wr, input logic [9:0] a, input logic [15:0] d);
    apb(1'b1, H_ADDR, {22'h0, a});
    apb(1'b1, H_WDATA, {16'h0, d});
    apb(1'b1, H_CTRL, wr ? 32'h1 : 32'h2);
    do apb(1'b0, H_STATUS, 32'h0); while (rd[0] !== 1'b0);
    if (!wr) apb(1'b0, H_RDATA, 32'h0);
  endtask : acc

  task automatic wr(input logic [1:0] c, input logic [7:0] o, input logic [15:0] d);
    acc(1'b1, {c, o}, d);
  endtask : wr

  task automatic pulse(input logic [3:0] p);
    apb(1'b1, H_SYNC, {28'h0, p});
    apb(1'b1, H_SYNC, 32'h0);
    repeat (20) @(posedge pclk);
  endtask : pulse

  task automatic t_reset();
    check(32'(awake), 32'h0);
    acc(1'b0, {2'd0, EXT_SLEEP}, 16'h0);
    check(rd, 32'hf);
    // host registers read back what was last placed on the port
    apb(1'b0, H_ADDR, 32'h0);
    check(rd, 32'(EXT_SLEEP));
    apb(1'b1, H_WDATA, 32'h1234);
    apb(1'b0, H_WDATA, 32'h0);
    check(rd, 32'h1234);
    apb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    check(32'(pslverr), 32'h0);
    $display("reset test done");
  endtask : t_reset

  task automatic t_soft_start();
    wr(2'd0, CH_START, 16'd5);
    wr(2'd1, CH_START, 16'd0);
    wr(2'd0, EXT_SOFT, 16'h13);
    repeat (30) @(posedge pclk);
    check(32'(wake_at[0] - ack_at), 32'd11);
    check(32'(awake), 32'h1);
    acc(1'b0, {2'd0, CH_START}, 16'h0);
    check(rd, 32'd5);
    // external soft write copied its start/hop bits into every channel
    acc(1'b0, {2'd2, CH_SOFT}, 16'h0);
    check(rd, 32'h10);
    $display("soft start test done");
  endtask : t_soft_start

  task automatic t_pin_start();
    for (int s = 0; s < 4; s++) begin
      wr(2'd0, EXT_SLEEP, 16'hf);
      wr(2'd2, CH_SEL, 16'(s << 7));
      wr(2'd2, CH_START, 16'd3);
      wr(2'd0, EXT_PIN, 16'h1f);
      pulse(4'(1 << s));
      check(32'(wake_at[2] - pin_at), 32'd6);
      check(32'(awake[0]), 32'(s == 0));
    end
    // read back select, pin enables and the per-channel pin mirror
    acc(1'b0, {2'd2, CH_SEL}, 16'h0);
    check(rd, 32'h180);
    acc(1'b0, {2'd0, EXT_PIN}, 16'h0);
    check(rd, 32'h1f);
    acc(1'b0, {2'd1, CH_PIN}, 16'h0);
    check(rd, 32'h10);
    $display("pin start test done");
  endtask : t_pin_start

  task automatic t_soft_hop();
    wr(2'd3, CH_FREQ, 16'd4);
    wr(2'd3, CH_FLO, 16'h5678);
    wr(2'd3, CH_FHI, 16'h1234);
    wr(2'd0, EXT_SOFT, 16'h28);
    repeat (30) @(posedge pclk);
    check(32'(load_at[3] - ack_at), 32'd11);
    check(freq[3], 32'h12345678);
    wr(2'd3, CH_FLO, 16'h9abc);
    check(freq[3], 32'h12345678);
    wr(2'd3, CH_SOFT, 16'h20);
    repeat (30) @(posedge pclk);
    check(32'(load_at[3] - ack_at), 32'd11);
    check(freq[3], 32'h12349abc);
    $display("soft hop test done");
  endtask : t_soft_hop

  task automatic t_wake();
    wr(2'd3, CH_START, 16'd2);
    wr(2'd0, EXT_SLEEP, 16'h7);
    repeat (30) @(posedge pclk);
    check(32'(wake_at[3] - ack_at), 32'd8);
    check(32'(load_at[3] - ack_at), 32'd11);
    $display("wake test done");
  endtask : t_wake

  task automatic t_pin_hop();
    wr(2'd0, CH_SEL, 16'h0);
    wr(2'd0, CH_FREQ, 16'd2);
    wr(2'd0, EXT_PIN, 16'h21);
    pulse(4'h1);
    check(32'(load_at[0] - pin_at), 32'd7);
    wr(2'd0, EXT_PIN, 16'h61);
    n = load_cnt[0];
    pulse(4'h1);
    pulse(4'h1);
    check(32'(load_cnt[0] - n), 32'd1);
    wr(2'd0, EXT_PIN, 16'h21);
    pulse(4'h1);
    check(32'(load_cnt[0] - n), 32'd2);
    $display("pin hop test done");
  endtask : t_pin_hop

  // hard reset in mid-run must put an awake channel back to sleep
  task automatic t_hard_reset();
    check(32'(awake[3]), 32'h1);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    check(32'(awake), 32'h0);
    presetn <= 1'b1;
    acc(1'b0, {2'd0, EXT_SLEEP}, 16'h0);
    check(rd, 32'hf);
    $display("hard reset test done");
  endtask : t_hard_reset

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  // watchdog well beyond the expected run
  initial begin
    #200000;
    err_total++;
    summarize();
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_soft_start();
    t_pin_start();
    t_soft_hop();
    t_wake();
    t_pin_hop();
    t_hard_reset();
    summarize();
  end
endmodule : tb_channel_start_hop_sync
`default_nettype wire
